/* src/adcsq_pkg.sv */
// Package for the scan/inject sequencer of the converter control block.
// Assumes a 20 MHz module clock and a simple strobe register port.
package adcsq_pkg;

  // Register word offsets
  localparam logic [3:0] ADCSQ_OFF_CTRL0 = 4'h0;
  localparam logic [3:0] ADCSQ_OFF_STATUS = 4'h1;
  localparam logic [3:0] ADCSQ_OFF_MAIN_RES = 4'h2;
  localparam logic [3:0] ADCSQ_OFF_INJ_RES = 4'h3;

  // Control register field positions
  localparam int ADCSQ_CTRL_MODE_LSB = 0;
  localparam int ADCSQ_CTRL_START = 2;
  localparam int ADCSQ_CTRL_WAIT_RD = 3;
  localparam int ADCSQ_CTRL_INJ_EN = 4;
  localparam int ADCSQ_CTRL_INJ_REQ = 5;
  localparam int ADCSQ_CTRL_CAL_OFF = 6;
  localparam int ADCSQ_CTRL_CH_LSB = 8;

  // Status register field positions
  localparam int ADCSQ_ST_BUSY = 0;
  localparam int ADCSQ_ST_DONE = 1;
  localparam int ADCSQ_ST_OVR_INJ = 2;
  localparam int ADCSQ_ST_CAL = 3;
  localparam int ADCSQ_ST_BUF_FULL = 4;

  // Result register layout
  localparam int ADCSQ_RES_W = 12;
  localparam int ADCSQ_CH_W = 4;
  localparam int ADCSQ_RES_CH_LSB = 12;

  // Conversion modes
  localparam logic [1:0] ADCSQ_MODE_SCAN_SINGLE = 2'h2;
  localparam logic [1:0] ADCSQ_MODE_SCAN_CONT = 2'h3;

  // Reset values
  localparam logic [15:0] ADCSQ_RST_WORD = 16'h0000;

  // Timing: basic clock equals module clock here
  localparam int ADCSQ_CLK_HZ = 20000000;
  localparam int ADCSQ_BC_HZ = 20000000;
  localparam int ADCSQ_RESET_CAL_BC = 11696;
  localparam int ADCSQ_RESET_CAL_CYC = ADCSQ_RESET_CAL_BC * (ADCSQ_CLK_HZ / ADCSQ_BC_HZ);
  localparam int ADCSQ_CONV_CYC = 48;
  localparam int ADCSQ_POSTCAL_CYC = 12;

  typedef enum logic [2:0] {
    ADCSQ_ST_RESET_CAL,
    ADCSQ_ST_IDLE,
    ADCSQ_ST_CONVERT,
    ADCSQ_ST_POST_CAL,
    ADCSQ_ST_HOLD
  } adcsq_state_e;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } adcsq_bus_s;

  // Analog core interface
  typedef struct packed {
    logic start;
    logic [3:0] channel;
  } adcsq_core_s;

endpackage

/* src/adcsq_sequencer.sv */
// Scan, wait-for-read and injection sequencer for the converter.
// Assumes a SAR core that answers start with a done pulse and result.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module adcsq_sequencer
  import adcsq_pkg::*;
#(
  parameter int RESET_CAL_CYC = ADCSQ_RESET_CAL_CYC,
  parameter int CONV_CYC = ADCSQ_CONV_CYC,
  parameter int POSTCAL_CYC = ADCSQ_POSTCAL_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic capture_compare_ch_trigger,
  input wire logic pwm_timer_trigger,
  output logic core_start,
  output logic [3:0] core_channel,
  input wire logic core_done,
  input wire logic [11:0] core_result,
  output logic conv_busy_flag,
  output logic cal_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam logic [15:0] CNT_W_MAX = 16'hffff;
  adcsq_state_e state_ff;
  logic [15:0] cnt_ff;
  logic [1:0] conv_mode_sel_ff;
  logic conv_start_bit_ff;
  logic wait_read_enable_ff;
  logic inject_enable_ff;
  logic inject_request_bit_ff;
  logic post_cal_disable_ff;
  logic [3:0] start_channel_sel_ff;
  logic conv_done_flag_ff;
  logic overrun_inject_flag_ff;
  logic [15:0] main_result_reg_ff;
  logic [11:0] inj_result_ff;
  logic [3:0] inj_channel_ff;
  logic main_unread_ff;
  logic inj_unread_ff;
  logic [15:0] tmp_buf_ff;
  logic tmp_full_ff;
  logic busy_ff;
  logic [3:0] cur_ch_ff;
  logic cur_inj_ff;
  logic std_pend_ff;
  logic inj_pend_ff;
  logic stop_req_ff;
  logic [15:0] rdata_ff;
  logic core_start_ff;
  logic wr_ctrl;
  logic start_rise;
  logic req_rise_sw;
  logic inj_trig;
  logic inj_active;
  logic rd_main;
  logic rd_inj;
  logic conv_end;
  logic std_end;
  logic inj_end;
  logic last_in_seq;
  logic seq_more;
  logic launch_inj;
  logic launch_std;
  logic restart_ff;

  // Cycle count of a given length, clipped to the counter
  function automatic logic [15:0] cyc16(input int n);
    cyc16 = (n > 65535) ? CNT_W_MAX : 16'(n);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign wr_ctrl = reg_wr && (reg_addr == ADCSQ_OFF_CTRL0);
  assign rd_main = reg_rd && (reg_addr == ADCSQ_OFF_MAIN_RES);
  assign rd_inj = reg_rd && (reg_addr == ADCSQ_OFF_INJ_RES);
  assign start_rise = wr_ctrl && reg_wdata[ADCSQ_CTRL_START] && !conv_start_bit_ff;
  assign req_rise_sw = wr_ctrl && reg_wdata[ADCSQ_CTRL_INJ_REQ] && !inject_request_bit_ff;
  // Only a 0-to-1 change of the request bit counts as a new injection request
  assign inj_trig = req_rise_sw || ((capture_compare_ch_trigger || pwm_timer_trigger) && !inject_request_bit_ff);
  assign inj_active = inject_enable_ff && wait_read_enable_ff;
  // With post-calibration off the conversion ends straight from the convert phase
  assign conv_end = ((state_ff == ADCSQ_ST_POST_CAL) && (cnt_ff == 16'h0000)) ||
    ((state_ff == ADCSQ_ST_CONVERT) && post_cal_disable_ff && (core_done || cnt_ff == 16'h0000) &&
    !(start_rise && !cur_inj_ff));
  assign std_end = conv_end && !cur_inj_ff;
  assign inj_end = conv_end && cur_inj_ff;
  assign last_in_seq = (cur_ch_ff == 4'h0) || !conv_mode_sel_ff[1];
  // More conversions follow this one in the scan
  assign seq_more = !last_in_seq || (conv_mode_sel_ff == ADCSQ_MODE_SCAN_CONT && conv_start_bit_ff);
  // Injection has priority at every launch point
  assign launch_inj = inj_pend_ff && inj_active && (state_ff == ADCSQ_ST_IDLE);
  assign launch_std = std_pend_ff && !launch_inj && !tmp_full_ff && (state_ff == ADCSQ_ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_mode_sel_ff <= 2'h0;
      wait_read_enable_ff <= 1'b0;
      inject_enable_ff <= 1'b0;
      post_cal_disable_ff <= 1'b0;
      start_channel_sel_ff <= 4'h0;
      inj_channel_ff <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        conv_mode_sel_ff <= reg_wdata[ADCSQ_CTRL_MODE_LSB +: 2];
        wait_read_enable_ff <= reg_wdata[ADCSQ_CTRL_WAIT_RD];
        inject_enable_ff <= reg_wdata[ADCSQ_CTRL_INJ_EN];
        post_cal_disable_ff <= reg_wdata[ADCSQ_CTRL_CAL_OFF];
        start_channel_sel_ff <= reg_wdata[ADCSQ_CTRL_CH_LSB +: 4];
      end
      // Only software writes the injection channel
      if (reg_wr && reg_addr == ADCSQ_OFF_INJ_RES) begin
        inj_channel_ff <= reg_wdata[ADCSQ_RES_CH_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start bit: software write, hardware clear at single scan end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start_bit_ff <= 1'b0;
    end else if (wr_ctrl) begin
      conv_start_bit_ff <= reg_wdata[ADCSQ_CTRL_START];
    end else if (std_end && last_in_seq && (conv_mode_sel_ff == ADCSQ_MODE_SCAN_SINGLE || !conv_mode_sel_ff[1])) begin
      conv_start_bit_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Injection request bit; set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inject_request_bit_ff <= 1'b0;
    end else if (capture_compare_ch_trigger || pwm_timer_trigger) begin
      inject_request_bit_ff <= 1'b1;
    end else if (wr_ctrl) begin
      inject_request_bit_ff <= reg_wdata[ADCSQ_CTRL_INJ_REQ];
    end else if (launch_inj) begin
      inject_request_bit_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inj_pend_ff <= 1'b0;
    end else if (inj_trig) begin
      inj_pend_ff <= 1'b1;
    end else if (launch_inj || (wr_ctrl && !reg_wdata[ADCSQ_CTRL_INJ_REQ])) begin
      // Launched, or a stale request dropped by a software clear
      inj_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      std_pend_ff <= 1'b0;
      stop_req_ff <= 1'b0;
    end else begin
      if (start_rise) begin
        std_pend_ff <= 1'b1;
      end else if (launch_std) begin
        std_pend_ff <= 1'b0;
      end else if (std_end && seq_more && conv_mode_sel_ff[1]) begin
        std_pend_ff <= 1'b1;
      end
      // Start cleared mid-scan: finish the sequence then stop
      if (wr_ctrl && !reg_wdata[ADCSQ_CTRL_START] && busy_ff) begin
        stop_req_ff <= 1'b1;
      end else if (!busy_ff) begin
        stop_req_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state, channel and timing counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ADCSQ_ST_RESET_CAL;
      cnt_ff <= 16'h0000;
      cur_ch_ff <= 4'h0;
      cur_inj_ff <= 1'b0;
      core_start_ff <= 1'b0;
    end else begin
      core_start_ff <= 1'b0;
      case (state_ff)
        ADCSQ_ST_RESET_CAL: begin
          if (cnt_ff >= cyc16(RESET_CAL_CYC - 1)) begin
            state_ff <= ADCSQ_ST_IDLE;
            cnt_ff <= 16'h0000;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ADCSQ_ST_IDLE: begin
          if (launch_inj) begin
            cur_inj_ff <= 1'b1;
            state_ff <= ADCSQ_ST_CONVERT;
            cnt_ff <= cyc16(CONV_CYC - 1);
            core_start_ff <= 1'b1;
          end else if (launch_std) begin
            cur_inj_ff <= 1'b0;
            // New sequence from select, else next lower channel
            if (!busy_ff || !conv_mode_sel_ff[1] || cur_ch_ff == 4'h0 || restart_ff) begin
              cur_ch_ff <= start_channel_sel_ff;
            end else begin
              cur_ch_ff <= cur_ch_ff - 4'h1;
            end
            state_ff <= ADCSQ_ST_CONVERT;
            cnt_ff <= cyc16(CONV_CYC - 1);
            core_start_ff <= 1'b1;
          end
        end
        ADCSQ_ST_CONVERT: begin
          if (start_rise && !cur_inj_ff) begin
            state_ff <= ADCSQ_ST_IDLE;
          end else if (core_done || cnt_ff == 16'h0000) begin
            state_ff <= post_cal_disable_ff ? ADCSQ_ST_IDLE : ADCSQ_ST_POST_CAL;
            cnt_ff <= post_cal_disable_ff ? 16'h0000 : cyc16(POSTCAL_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ADCSQ_ST_POST_CAL: begin
          if (start_rise && !cur_inj_ff) begin
            state_ff <= ADCSQ_ST_IDLE;
          end else if (cnt_ff == 16'h0000) begin
            state_ff <= ADCSQ_ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= ADCSQ_ST_IDLE;
        end
      endcase
    end
  end

  // A fresh start restarts the scan at the selected channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_ff <= 1'b0;
    end else if (start_rise) begin
      restart_ff <= 1'b1;
    end else if (launch_std) begin
      restart_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
    end else if (start_rise) begin
      busy_ff <= 1'b1;
    end else if (std_end && !seq_more && !tmp_full_ff) begin
      busy_ff <= 1'b0;
    end else if (std_end && stop_req_ff && last_in_seq) begin
      busy_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers, buffer, flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      main_result_reg_ff <= ADCSQ_RST_WORD;
      main_unread_ff <= 1'b0;
      tmp_buf_ff <= ADCSQ_RST_WORD;
      tmp_full_ff <= 1'b0;
      conv_done_flag_ff <= 1'b0;
      overrun_inject_flag_ff <= 1'b0;
    end else begin
      if (std_end) begin
        if (wait_read_enable_ff && main_unread_ff && !rd_main) begin
          tmp_buf_ff <= {cur_ch_ff, core_result};
          tmp_full_ff <= 1'b1;
        end else begin
          main_result_reg_ff <= {cur_ch_ff, core_result};
          main_unread_ff <= 1'b1;
          conv_done_flag_ff <= 1'b1;
          if (main_unread_ff && !rd_main) begin
            overrun_inject_flag_ff <= 1'b1;
          end
        end
      end else if (rd_main && tmp_full_ff) begin
        main_result_reg_ff <= tmp_buf_ff;
        tmp_full_ff <= 1'b0;
        conv_done_flag_ff <= 1'b1;
      end else if (rd_main) begin
        main_unread_ff <= 1'b0;
      end
      if (inj_end) begin
        overrun_inject_flag_ff <= 1'b1;
      end
      if (reg_wr && reg_addr == ADCSQ_OFF_STATUS && !std_end && !inj_end && !(rd_main && tmp_full_ff)) begin
        conv_done_flag_ff <= conv_done_flag_ff & ~reg_wdata[ADCSQ_ST_DONE];
        overrun_inject_flag_ff <= overrun_inject_flag_ff & ~reg_wdata[ADCSQ_ST_OVR_INJ];
      end
    end
  end

  // Injected result written directly, overwriting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inj_result_ff <= 12'h000;
      inj_unread_ff <= 1'b0;
    end else if (inj_end) begin
      inj_result_ff <= core_result;
      inj_unread_ff <= 1'b1;
    end else if (rd_inj) begin
      inj_unread_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= ADCSQ_RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        ADCSQ_OFF_CTRL0: rdata_ff <= {4'h0, start_channel_sel_ff, 1'b0, post_cal_disable_ff,
          inject_request_bit_ff, inject_enable_ff, wait_read_enable_ff, conv_start_bit_ff, conv_mode_sel_ff};
        ADCSQ_OFF_STATUS: rdata_ff <= {11'h000, tmp_full_ff, (state_ff == ADCSQ_ST_RESET_CAL),
          overrun_inject_flag_ff, conv_done_flag_ff, busy_ff};
        ADCSQ_OFF_MAIN_RES: rdata_ff <= main_result_reg_ff;
        ADCSQ_OFF_INJ_RES: rdata_ff <= {inj_channel_ff, inj_result_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; channel follows live injection field
  assign reg_rdata = rdata_ff;
  assign core_start = core_start_ff;
  assign core_channel = cur_inj_ff ? inj_channel_ff : cur_ch_ff;
  assign conv_busy_flag = busy_ff;
  assign cal_busy = (state_ff == ADCSQ_ST_RESET_CAL);

endmodule

/* test/adc_scan_inject_sequencer_tb_top.sv */
// Self-checking bench for the scan/inject sequencer.
// Assumes shortened calibration and conversion counts.
`timescale 1ns/10ps
module adc_scan_inject_sequencer_tb_top;
  import adcsq_pkg::*;
  localparam int CAL = 20;
  localparam int POST = 2;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] dly;
    logic [15:0] exp_ctrl;
  } adcsq_row_s;
  adcsq_row_s rows [3] = '{'{16'h030e, 4'h3, 16'h030a}, '{16'h000e, 4'h6, 16'h000a}, '{16'h010e, 4'h3, 16'h010a}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic capture_compare_ch_trigger = 1'b0;
  logic pwm_timer_trigger = 1'b0;
  logic [3:0] delay = 4'h3;
  logic [15:0] reg_rdata;
  logic core_start;
  logic [3:0] core_channel;
  logic core_done;
  logic [11:0] core_result;
  logic conv_busy_flag;
  logic cal_busy;
  logic [15:0] d;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  adcsq_sequencer #(.RESET_CAL_CYC(CAL), .CONV_CYC(8), .POSTCAL_CYC(POST)) uut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_compare_ch_trigger(capture_compare_ch_trigger), .pwm_timer_trigger(pwm_timer_trigger),
    .core_start(core_start), .core_channel(core_channel), .core_done(core_done), .core_result(core_result),
    .conv_busy_flag(conv_busy_flag), .cal_busy(cal_busy));
  adcsq_core_model u_core (.clk(clk), .reset_n(reset_n), .core_start(core_start), .core_channel(core_channel),
    .delay(delay), .core_done(core_done), .core_result(core_result));
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic wait_flag(input int idx, input int tries);
    int n;
    n = 0;
    rd(ADCSQ_OFF_STATUS);
    while (d[idx] !== 1'b1 && n < tries) begin
      rd(ADCSQ_OFF_STATUS);
      n++;
    end
  endtask
  task automatic take_main(input logic [3:0] ch);
    wait_flag(ADCSQ_ST_DONE, 60);
    chk("done flag", d & 16'h0002, 16'h0002);
    wr(ADCSQ_OFF_STATUS, 16'h0002);
    rd(ADCSQ_OFF_MAIN_RES);
    chk("main result", d, {ch, 8'h5a, ch});
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    @(negedge clk);
    while (conv_busy_flag !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 1) begin
      capture_compare_ch_trigger <= 1'b1;
    end else begin
      pwm_timer_trigger <= 1'b1;
    end
    @(posedge clk);
    capture_compare_ch_trigger <= 1'b0;
    pwm_timer_trigger <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("timeout");
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    int t_on;
    int t_off;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("cal after reset", {15'h0000, cal_busy}, 16'h0001);
    rd(ADCSQ_OFF_STATUS);
    chk("status cal bit", d & 16'h0008, 16'h0008);
    n = 0;
    while (cal_busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("cal length", {15'h0000, n <= CAL}, 16'h0001);
    for (int a = 0; a < 4; a++) begin
      rd(a == 1 ? 4'h9 : 4'(a));
      chk("reset word", d, ADCSQ_RST_WORD);
    end
    $display("reset test done");
    // Single scans from the table
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      delay <= rows[i].dly;
      wr(ADCSQ_OFF_CTRL0, rows[i].ctrl);
      for (int c = int'(rows[i].ctrl[11:8]); c >= 0; c--) begin
        take_main(4'(c));
      end
      wait_idle(n);
      chk("busy end", {15'h0000, conv_busy_flag}, 16'h0000);
      rd(ADCSQ_OFF_CTRL0);
      chk("ctrl end", d, rows[i].exp_ctrl);
      $display("row %0d done", i);
    end
    // Continuous scan, then stop in mid-sequence
    wr(ADCSQ_OFF_CTRL0, 16'h010f);
    take_main(4'h1);
    take_main(4'h0);
    wait_flag(ADCSQ_ST_DONE, 60);
    wr(ADCSQ_OFF_CTRL0, 16'h010b);
    take_main(4'h1);
    take_main(4'h0);
    wait_idle(n);
    chk("stop busy", {15'h0000, conv_busy_flag}, 16'h0000);
    rd(ADCSQ_OFF_STATUS);
    chk("no extra done", d & 16'h0002, 16'h0000);
    $display("continuous test done");
    // Overrun without wait-for-read
    wr(ADCSQ_OFF_CTRL0, 16'h0106);
    wait_idle(n);
    rd(ADCSQ_OFF_STATUS);
    chk("overrun flag", d & 16'h0004, 16'h0004);
    rd(ADCSQ_OFF_MAIN_RES);
    chk("overwritten result", d, 16'h05a0);
    wr(ADCSQ_OFF_STATUS, 16'h0006);
    // Post-calibration on and off
    wr(ADCSQ_OFF_CTRL0, 16'h0006);
    wait_idle(t_on);
    wr(ADCSQ_OFF_CTRL0, 16'h0046);
    wait_idle(t_off);
    chk("postcal cycles", 16'(t_on - t_off), 16'(POST));
    wr(ADCSQ_OFF_STATUS, 16'h0006);
    $display("overrun and postcal tests done");
    // Injection by software, capture event and timer match
    for (int k = 0; k < 3; k++) begin
      wr(ADCSQ_OFF_CTRL0, 16'h0018);
      wr(ADCSQ_OFF_INJ_RES, {4'(5 + k), 12'h000});
      if (k == 0) begin
        wr(ADCSQ_OFF_CTRL0, 16'h0038);
      end else begin
        pulse(k);
      end
      wait_flag(ADCSQ_ST_OVR_INJ, 60);
      chk("inject flag", d & 16'h0004, 16'h0004);
      wr(ADCSQ_OFF_STATUS, 16'h0004);
      rd(ADCSQ_OFF_INJ_RES);
      chk("inject result", d, {4'(5 + k), 8'h5a, 4'(5 + k)});
    end
    // Trigger without wait-for-read is only recorded
    wr(ADCSQ_OFF_CTRL0, 16'h0010);
    pulse(1);
    wait_flag(ADCSQ_ST_OVR_INJ, 15);
    chk("no inject", d & 16'h0004, 16'h0000);
    rd(ADCSQ_OFF_CTRL0);
    chk("request kept", d & 16'h0020, 16'h0020);
    // Clearing the stale request while enabling must not inject
    wr(ADCSQ_OFF_CTRL0, 16'h0018);
    wait_flag(ADCSQ_ST_OVR_INJ, 15);
    chk("stale cleared no inject", d & 16'h0004, 16'h0000);
    pulse(2);
    wait_flag(ADCSQ_ST_OVR_INJ, 60);
    chk("trigger edge inject", d & 16'h0004, 16'h0004);
    $display("injection tests done");
    give_verdict();
  end
endmodule

/* test/adcsq_core_model.sv */
// Behavioural SAR core answering a start pulse after a set delay.
// Assumes delay between 1 and two less than the design's conversion length.
`timescale 1ns/10ps
module adcsq_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic core_start,
  input wire logic [3:0] core_channel,
  input wire logic [3:0] delay,
  output logic core_done,
  output logic [11:0] core_result
);
  logic run_ff;
  logic [3:0] cnt_ff;
  logic [3:0] ch_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Conversion countdown; result stable from done on, toggling before
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_ff <= 1'b0;
      cnt_ff <= 4'h0;
      ch_ff <= 4'h0;
      core_done <= 1'b0;
      core_result <= 12'h000;
    end else begin
      core_done <= 1'b0;
      if (core_start) begin
        run_ff <= 1'b1;
        cnt_ff <= delay;
        ch_ff <= core_channel;
        core_result <= ~core_result;
      end else if (run_ff && cnt_ff == 4'h1) begin
        run_ff <= 1'b0;
        core_done <= 1'b1;
        core_result <= {8'h5a, ch_ff};
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
        core_result <= ~core_result;
      end
    end
  end
endmodule

/* test/adcsq_seq_chk.sv */
// Port-level properties of the scan/inject sequencer.
// Assumes one clock domain and the register port of the top module.
`timescale 1ns/10ps
module adcsq_seq_chk
  import adcsq_pkg::*;
#(
  parameter int RESET_CAL_CYC = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic capture_compare_ch_trigger,
  input wire logic pwm_timer_trigger,
  input wire logic core_start,
  input wire logic [3:0] core_channel,
  input wire logic core_done,
  input wire logic [11:0] core_result,
  input wire logic conv_busy_flag,
  input wire logic cal_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] cal_cnt_ff;
  logic [15:0] nxt_cal_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Length of the running calibration
  assign nxt_cal_cnt = cal_busy ? cal_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_cnt_ff <= 16'h0000;
    end else begin
      cal_cnt_ff <= nxt_cal_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Idle converter and a scan start written
  sequence s_idle;
    !conv_busy_flag && !cal_busy;
  endsequence
  sequence s_scan_start;
    reg_wr && reg_addr == ADCSQ_OFF_CTRL0 && reg_wdata[ADCSQ_CTRL_START] && reg_wdata[1];
  endsequence
  a_start_launch: assert property (s_idle ##0 s_scan_start |-> ##[1:3] core_start)
    else $error("scan start did not launch a conversion");
  a_busy_set: assert property (s_idle ##0 s_scan_start |=> conv_busy_flag)
    else $error("busy not set after start");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ADCSQ_OFF_INJ_RES |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_cal: assert property (reg_rd && reg_addr == ADCSQ_OFF_STATUS |=> reg_rdata[ADCSQ_ST_CAL] == $past(cal_busy))
    else $error("status calibration bit wrong");
  a_status_busy: assert property (reg_rd && reg_addr == ADCSQ_OFF_STATUS |=> reg_rdata[ADCSQ_ST_BUSY] == $past(conv_busy_flag))
    else $error("status busy bit wrong");
  a_start_one_pulse: assert property (core_start |=> !core_start)
    else $error("core start longer than one cycle");
  a_no_start_cal: assert property (cal_busy |-> !core_start)
    else $error("conversion during calibration");
  a_cal_bounded: assert property (cal_cnt_ff <= RESET_CAL_CYC + 1)
    else $error("calibration too long");
endmodule
bind adcsq_sequencer adcsq_seq_chk #(.RESET_CAL_CYC(RESET_CAL_CYC)) u_chk (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .capture_compare_ch_trigger(capture_compare_ch_trigger), .pwm_timer_trigger(pwm_timer_trigger),
  .core_start(core_start), .core_channel(core_channel), .core_done(core_done), .core_result(core_result),
  .conv_busy_flag(conv_busy_flag), .cal_busy(cal_busy));
